//--- bench/dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module dev_model (
  input wire logic i_ce_n,
  input wire logic i_ts_n,
  input wire logic i_oe_n,
  input wire logic i_rw_n,
  input wire logic [13:0] i_a,
  input wire logic [15:0] i_d,
  input wire logic i_ms,
  input wire logic i_bsy_n,
  input wire logic i_fce_n,
  input wire logic [13:0] i_fa,
  input wire logic i_fwe,
  input wire logic i_fd,
  output logic o_bsy_n,
  output logic o_fbsy_n,
  output logic [15:0] o_q,
  output logic [7:0] o_frd
);
  logic [15:0] mem [0:16383];
  logic [1:0] own [0:7];
  logic [1:0] pend [0:7];
  logic [15:0] sq = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic lose = 1'h0;
  wire m = !i_ce_n && !i_fce_n && i_a == i_fa;
  // all tokens free, no requests
  initial for (int k = 0; k < 8; k++) begin
    own[k] = 2'h0;
    pend[k] = 2'h0;
  end
  task automatic sw(input logic [1:0] w, input logic [2:0] k, input logic d);
    if (!d && own[k] == 2'h0) own[k] = w;
    else if (!d && own[k] != w) pend[k] = pend[k] | w;
    else if (d && own[k] == w) begin
      own[k] = (pend[k] & ~w) != 2'h0 ? ~w : 2'h0;
      pend[k] = 2'h0;
    end else if (d) pend[k] = pend[k] & ~w;
  endtask
  // whoever settles into the match last loses
  always @(negedge i_ce_n or i_a) #1 lose = m;
  always @(negedge m) lose = 1'h0;
  // one busy at most, only as master
  assign o_bsy_n = !(i_ms && lose);
  assign o_fbsy_n = !(i_ms && m && !lose);
  // gated strobe, full depth, bit 0 of token data
  always @(posedge i_rw_n) begin
    if (!i_ce_n && (i_ms ? !lose : i_bsy_n)) mem[i_a] = i_d;
    if (!i_ts_n) sw(2'h1, i_a[2:0], i_d[0]);
  end
  // far side token writes
  always @(posedge i_fwe) sw(2'h2, i_fa[2:0], i_fd);
  // flag spread over all bits, frozen while both stay low
  always @(negedge i_oe_n or negedge i_ts_n)
    if (!i_oe_n && !i_ts_n) sq = {16{own[i_a[2:0]] != 2'h1}};
  // released bus flips, so stale data never reads as good
  always @* begin
    if (!i_oe_n && i_rw_n && !i_ts_n) o_q = sq;
    else if (!i_oe_n && i_rw_n && !i_ce_n) o_q = mem[i_a];
    else o_q = ~last;
    if (o_q != ~last) last = o_q;
  end
  // far side view of each flag
  always @* for (int k = 0; k < 8; k++) o_frd[k] = own[k] != 2'h2;
endmodule
`default_nettype wire

//--- bench/dpram_port_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dpram_port_checker #(
  parameter int N_PARTS = 1,
  parameter bit ARB_DISABLE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [N_PARTS-1:0] i_own_contention_flag_n,
  input wire logic [N_PARTS-1:0] i_far_contention_flag_n,
  input wire logic o_ce_n,
  input wire logic o_token_space_select_n,
  input wire logic o_rw_n,
  input wire logic o_busy_wait,
  input wire logic o_contention,
  input wire logic o_master_sel,
  input wire logic o_busy_tie_n,
  input wire logic o_busy_tie_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // pin protocol
  token_select_a: assert property (!o_token_space_select_n |-> o_ce_n)
    else $error("token space and array selected together");
  strap_level_a: assert property (o_master_sel == !ARB_DISABLE && o_busy_tie_oe == ARB_DISABLE && o_busy_tie_n)
    else $error("strap or busy tie-off wrong");
  // ==========================================================
  // busy handling, sync latency of three edges
  own_busy_flag_a: assert property ((!(&i_own_contention_flag_n)) [*3] |=> o_contention)
    else $error("own busy not flagged");
  far_busy_flag_a: assert property ((!(&i_far_contention_flag_n)) [*3] |=> o_contention)
    else $error("far busy not flagged");
  quiet_flag_a: assert property (((&i_own_contention_flag_n) && (&i_far_contention_flag_n)) [*3] |=> !o_contention)
    else $error("flag without busy");
  stall_hold_a: assert property (o_busy_wait |-> o_rw_n && !o_ce_n)
    else $error("write strobe while stalled");
  stall_release_a: assert property ((&i_own_contention_flag_n) [*3] |=> ##[0:2] !o_busy_wait)
    else $error("stall outlives busy");
endmodule
bind dpram_port_host dpram_port_checker #(.N_PARTS(N_PARTS), .ARB_DISABLE(ARB_DISABLE)) chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_own_contention_flag_n(i_own_contention_flag_n),
  .i_far_contention_flag_n(i_far_contention_flag_n), .o_ce_n(o_ce_n),
  .o_token_space_select_n(o_token_space_select_n), .o_rw_n(o_rw_n), .o_busy_wait(o_busy_wait),
  .o_contention(o_contention), .o_master_sel(o_master_sel), .o_busy_tie_n(o_busy_tie_n),
  .o_busy_tie_oe(o_busy_tie_oe)
);
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dpram_host_pkg::*;
  typedef struct {cmd_t c; logic [13:0] a; logic [15:0] d; logic [15:0] q; logic g;} row_t;
  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic req = 1'h0;
  cmd_t cmd = CMD_READ;
  logic [13:0] addr = 14'h0000;
  logic [13:0] fa = 14'h0000;
  logic [15:0] wdata = 16'h0000;
  logic fce_n = 1'h1;
  logic fwe = 1'h0;
  logic fd = 1'h1;
  logic en = 1'h1;
  logic rdy, done, gr, bw, cont, ce_n, ts_n, oe_n, rw_n, dq_oe, ms, tie_n, tie_oe, bsy, fbsy;
  logic [13:0] pa;
  logic [15:0] rdata, dq_out, q;
  logic [7:0] frd;
  wire logic [15:0] dq = dq_oe ? dq_out : q;
  wire logic bl = tie_oe ? tie_n : bsy;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  row_t rows [9] = '{
    '{CMD_WRITE, 14'h0000, 16'hA5A5, 16'h0000, 1'h0},
    '{CMD_WRITE, 14'h3FFF, 16'h5A5A, 16'h0000, 1'h0},
    '{CMD_READ, 14'h0000, 16'h0000, 16'hA5A5, 1'h0},
    '{CMD_READ, 14'h3FFF, 16'h0000, 16'h5A5A, 1'h0},
    '{CMD_SEM_CLAIM, 14'h0003, 16'h0000, 16'h0000, 1'h1},
    '{CMD_SEM_READ, 14'h0004, 16'h0000, 16'hFFFF, 1'h1},
    '{CMD_SEM_READ, 14'h000B, 16'h0000, 16'h0000, 1'h1},
    '{CMD_SEM_RELEASE, 14'h0003, 16'h0001, 16'h0000, 1'h0},
    '{CMD_SEM_READ, 14'h0003, 16'h0000, 16'hFFFF, 1'h0}
  };
  dpram_port_host #(.N_PARTS(1), .ARB_DISABLE(1'b0)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_en(en), .i_req(req), .i_cmd(cmd), .i_addr(addr),
    .i_wdata(wdata), .o_ready(rdy), .o_done(done), .o_rdata(rdata), .o_granted(gr), .o_busy_wait(bw),
    .o_contention(cont), .o_ce_n(ce_n), .o_token_space_select_n(ts_n), .o_oe_n(oe_n), .o_rw_n(rw_n),
    .o_addr(pa), .o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq), .i_own_contention_flag_n(bl),
    .i_far_contention_flag_n(fbsy), .o_master_sel(ms), .o_busy_tie_n(tie_n), .o_busy_tie_oe(tie_oe)
  );
  dev_model dev (
    .i_ce_n(ce_n), .i_ts_n(ts_n), .i_oe_n(oe_n), .i_rw_n(rw_n), .i_a(pa), .i_d(dq_out), .i_ms(ms),
    .i_bsy_n(bl), .i_fce_n(fce_n), .i_fa(fa), .i_fwe(fwe), .i_fd(fd), .o_bsy_n(bsy), .o_fbsy_n(fbsy),
    .o_q(q), .o_frd(frd)
  );
  // ==========================================================
  // clock and hang guard
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [16:0] s, input logic [16:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one command, waits for the done pulse under a bound
  task automatic run(input cmd_t c, input logic [13:0] a, input logic [15:0] d);
    int k;
    @(negedge i_clk);
    cmd = c;
    addr = a;
    wdata = d;
    req = 1'h1;
    @(negedge i_clk);
    req = 1'h0;
    for (k = 0; k < 300 && done !== 1'h1; k++) @(negedge i_clk);
    check(done, 1'h1);
  endtask
  // far port token write to flag 3
  task automatic far(input logic d);
    @(negedge i_clk);
    fa = 14'h0003;
    fd = d;
    fwe = 1'h1;
    @(negedge i_clk);
    fwe = 1'h0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge i_clk);
    check({ms, tie_oe, tie_n}, 3'h5);
    check({ce_n, ts_n, rdy, cont}, 4'hE);
    i_rstn = 1'h1;
    foreach (rows[j]) begin
      run(rows[j].c, rows[j].a, rows[j].d);
      check(rdata, rows[j].q);
      check(gr, rows[j].g);
    end
    // frozen clock enable: a request must not be taken
    @(negedge i_clk);
    en = 1'h0;
    cmd = CMD_READ;
    req = 1'h1;
    repeat (3) @(negedge i_clk);
    check({rdy, ce_n, oe_n}, 3'h7);
    req = 1'h0;
    en = 1'h1;
    // hand-over with requests pending on both sides
    run(CMD_SEM_CLAIM, 14'h0003, 16'h0000);
    far(1'h0);
    check(frd[3], 1'h1);
    run(CMD_SEM_RELEASE, 14'h0003, 16'h0001);
    check(frd[3], 1'h0);
    run(CMD_SEM_CLAIM, 14'h0003, 16'h0000);
    check({gr, rdata}, 17'h0FFFF);
    far(1'h1);
    run(CMD_SEM_READ, 14'h0003, 16'h0000);
    check(rdata, 16'h0000);
    run(CMD_SEM_RELEASE, 14'h0003, 16'h0001);
    check(frd[3], 1'h1);
    // reset in mid-run drops the grant and parks the pins
    run(CMD_SEM_CLAIM, 14'h0005, 16'h0000);
    check(gr, 1'h1);
    @(negedge i_clk);
    i_rstn = 1'h0;
    @(negedge i_clk);
    check({gr, rdy, ce_n, ts_n, ms}, 5'h0F);
    i_rstn = 1'h1;
    // far port holds the address first, our write must wait
    fa = 14'h0010;
    fce_n = 1'h0;
    fork
      run(CMD_WRITE, 14'h0010, 16'h1234);
      begin
        repeat (30) @(negedge i_clk);
        check({bw, cont, rw_n, fbsy, bl}, 5'h1E);
        fce_n = 1'h1;
      end
    join
    // we hold the address first, so the far port gets the busy
    fork
      run(CMD_READ, 14'h0010, 16'h0000);
      begin
        repeat (2) @(negedge i_clk);
        fce_n = 1'h0;
        repeat (5) @(negedge i_clk);
        check({cont, fbsy, bl}, 3'h5);
        fce_n = 1'h1;
      end
    join
    check(rdata, 16'h1234);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- rtl/dpram_host_pkg.sv
`default_nettype none
package dpram_host_pkg;
  // ==========================================================
  // pin widths of one memory port
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam int SEM_SEL_W = 3;
  localparam int SEM_FLAG_BIT = 0;
  // ==========================================================
  // timing, figures in ns, counts derived at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int T_SETUP_NS = 20;
  localparam int T_STROBE_NS = 55;
  localparam int T_RECOVER_NS = 15;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 8;

  // least times round up, never below one cycle
  function automatic int ns_to_min_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = ns_to_min_cyc(T_SETUP_NS);
  localparam int STROBE_CYC = ns_to_min_cyc(T_STROBE_NS);
  localparam int RECOVER_CYC = ns_to_min_cyc(T_RECOVER_NS);
  // ==========================================================
  // data patterns for the token space
  localparam logic [DATA_W-1:0] SEM_CLAIM_DATA = 16'h0000;
  localparam logic [DATA_W-1:0] SEM_RELEASE_DATA = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_SEM_CLAIM,
    CMD_SEM_RELEASE,
    CMD_SEM_READ
  } cmd_t;

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } state_t;
endpackage
`default_nettype wire

//--- rtl/dpram_port_host.sv
// Overview of operation
// - disable arbitration: slave strap, busy high
// - cascaded depth: AND busy outputs per port
// - OR busy lines into illegal-access flag
// - token access: array select high, token low
`timescale 1ns/10ps
`default_nettype none
module dpram_port_host
  import dpram_host_pkg::*;
#(
  parameter int N_PARTS = 1,
  parameter bit ARB_DISABLE = 1'b0,
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  // user side
  input wire logic i_req,
  input wire dpram_host_pkg::cmd_t i_cmd,
  input wire logic [dpram_host_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dpram_host_pkg::DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_done,
  output logic [dpram_host_pkg::DATA_W-1:0] o_rdata,
  output logic o_granted,
  output logic o_busy_wait,
  output logic o_contention,
  // memory port pins
  output logic o_ce_n,
  output logic o_token_space_select_n,
  output logic o_oe_n,
  output logic o_rw_n,
  output logic [dpram_host_pkg::ADDR_W-1:0] o_addr,
  output logic [dpram_host_pkg::DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [dpram_host_pkg::DATA_W-1:0] i_dq_in,
  // busy lines of every part, this port and the opposite one
  input wire logic [N_PARTS-1:0] i_own_contention_flag_n,
  input wire logic [N_PARTS-1:0] i_far_contention_flag_n,
  // master/slave strap and busy tie-off
  output logic o_master_sel,
  output logic o_busy_tie_n,
  output logic o_busy_tie_oe
);
  import dpram_host_pkg::*;

  localparam int SYNC_W = DATA_W + 2 * N_PARTS;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYCLES);
  // array writes wait out the busy synchroniser, else the stall decision sees a stale busy
  localparam logic [CNT_W-1:0] WR_SETUP_CNT = CNT_W'(SETUP_CYCLES + SYNC_STAGES);
  // read strobe stretched so the synchronised data has landed
  localparam logic [CNT_W-1:0] RD_STROBE_CNT = CNT_W'(STROBE_CYCLES + SYNC_STAGES);
  localparam logic [CNT_W-1:0] WR_STROBE_CNT = CNT_W'(STROBE_CYCLES);
  localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RECOVER_CYCLES);
  localparam logic [SYNC_W-1:0] SYNC_RESET = {{(2 * N_PARTS){1'b1}}, DATA_ZERO};

  // ==========================================================
  // pin inputs through two flops
  logic [SYNC_W-1:0] sync_q;
  logic [DATA_W-1:0] dq_sync;
  logic [N_PARTS-1:0] own_busy_sync;
  logic [N_PARTS-1:0] far_busy_sync;
  logic own_busy_all_n;

  pin_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(i_en),
    .i_d({i_far_contention_flag_n, i_own_contention_flag_n, i_dq_in}),
    .o_q(sync_q)
  );

  assign dq_sync = sync_q[DATA_W-1:0];
  assign own_busy_sync = sync_q[DATA_W +: N_PARTS];
  assign far_busy_sync = sync_q[DATA_W + N_PARTS +: N_PARTS];
  assign own_busy_all_n = &own_busy_sync;

  // ==========================================================
  // access sequencer state
  state_t state, next_state;
  cmd_t cmd, next_cmd;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic phase, next_phase;
  logic is_wr, is_sem;
  logic next_ready, next_done, next_granted, next_busy_wait, next_contention;
  logic next_ce_n, next_sem_n, next_oe_n, next_rw_n, next_dq_oe;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_rdata, next_dq_out;

  // claim is a write of zero followed by a read-back
  always_comb begin
    is_sem = (cmd == CMD_SEM_CLAIM) || (cmd == CMD_SEM_RELEASE) || (cmd == CMD_SEM_READ);
    is_wr = (cmd == CMD_WRITE) || (cmd == CMD_SEM_RELEASE) || ((cmd == CMD_SEM_CLAIM) && !phase);
  end

  // next values of the sequencer and the pins
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_cnt = cnt;
    next_phase = phase;
    next_ready = o_ready;
    next_done = 1'b0;
    next_granted = o_granted;
    next_busy_wait = o_busy_wait;
    next_ce_n = o_ce_n;
    next_sem_n = o_token_space_select_n;
    next_oe_n = o_oe_n;
    next_rw_n = o_rw_n;
    next_addr = o_addr;
    next_dq_out = o_dq_out;
    next_dq_oe = o_dq_oe;
    next_rdata = o_rdata;
    next_contention = ~(&own_busy_sync) | ~(&far_busy_sync);
    case (state)
      ST_IDLE: begin
        if (i_req) begin
          next_cmd = i_cmd;
          next_phase = 1'b0;
          next_ready = 1'b0;
          next_cnt = (i_cmd == CMD_WRITE) ? WR_SETUP_CNT : SETUP_CNT;
          next_state = ST_SETUP;
          next_dq_oe = (i_cmd == CMD_WRITE) || (i_cmd == CMD_SEM_CLAIM) || (i_cmd == CMD_SEM_RELEASE);
          if ((i_cmd == CMD_READ) || (i_cmd == CMD_WRITE)) begin
            next_ce_n = 1'b0;
            next_sem_n = 1'b1;
            next_addr = i_addr;
            next_dq_out = i_wdata;
          end else begin
            // array select high, token select low
            next_ce_n = 1'b1;
            next_sem_n = 1'b0;
            next_addr = {ADDR_ZERO[ADDR_W-1:SEM_SEL_W], i_addr[SEM_SEL_W-1:0]};
            next_dq_out = (i_cmd == CMD_SEM_RELEASE) ? SEM_RELEASE_DATA : SEM_CLAIM_DATA;
          end
        end
      end
      ST_SETUP: begin
        // address held long enough for the master to decide
        if (cnt > CNT_ONE) begin
          next_cnt = cnt - CNT_ONE;
        end else if (!ARB_DISABLE && (cmd == CMD_WRITE) && !own_busy_all_n) begin
          // lost arbitration: stall rather than write into a gated strobe
          next_busy_wait = 1'b1;
        end else begin
          next_busy_wait = 1'b0;
          next_state = ST_STROBE;
          if (is_wr) begin
            next_rw_n = 1'b0;
            next_cnt = WR_STROBE_CNT;
          end else begin
            next_oe_n = 1'b0;
            next_cnt = RD_STROBE_CNT;
          end
        end
      end
      ST_STROBE: begin
        if (cnt > CNT_ONE) begin
          next_cnt = cnt - CNT_ONE;
        end else begin
          next_rw_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = RECOVER_CNT;
          next_state = ST_RECOVER;
          if (!is_wr) begin
            next_rdata = dq_sync;
          end
          if ((cmd == CMD_SEM_CLAIM) && phase) begin
            next_granted = ~dq_sync[SEM_FLAG_BIT];
          end
          if (cmd == CMD_SEM_RELEASE) begin
            next_granted = 1'b0;
          end
        end
      end
      ST_RECOVER: begin
        if (cnt > CNT_ONE) begin
          next_cnt = cnt - CNT_ONE;
        end else if ((cmd == CMD_SEM_CLAIM) && !phase) begin
          // token select held low; data driver dropped, the read strobe relatches the flag
          next_phase = 1'b1;
          next_dq_oe = 1'b0;
          next_cnt = SETUP_CNT;
          next_state = ST_SETUP;
        end else begin
          next_ce_n = 1'b1;
          next_sem_n = 1'b1;
          next_dq_oe = 1'b0;
          next_done = 1'b1;
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // registers only; clock enable freezes everything
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      cmd <= CMD_READ;
      cnt <= '0;
      phase <= 1'b0;
      o_ready <= 1'b1;
      o_done <= 1'b0;
      o_granted <= 1'b0;
      o_busy_wait <= 1'b0;
      o_contention <= 1'b0;
      o_ce_n <= 1'b1;
      o_token_space_select_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_rw_n <= 1'b1;
      o_addr <= '0;
      o_dq_out <= '0;
      o_dq_oe <= 1'b0;
      o_rdata <= '0;
      o_master_sel <= !ARB_DISABLE;
      o_busy_tie_n <= 1'b1;
      o_busy_tie_oe <= ARB_DISABLE;
    end else if (i_en) begin
      state <= next_state;
      cmd <= next_cmd;
      cnt <= next_cnt;
      phase <= next_phase;
      o_ready <= next_ready;
      o_done <= next_done;
      o_granted <= next_granted;
      o_busy_wait <= next_busy_wait;
      o_contention <= next_contention;
      o_ce_n <= next_ce_n;
      o_token_space_select_n <= next_sem_n;
      o_oe_n <= next_oe_n;
      o_rw_n <= next_rw_n;
      o_addr <= next_addr;
      o_dq_out <= next_dq_out;
      o_dq_oe <= next_dq_oe;
      o_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  // ==========================================================
  // two-flop synchroniser, one pair per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      logic next_meta;
      logic next_q;
      // first stage feeds only the second
      always_comb begin
        next_meta = i_en ? i_d[g] : meta;
        next_q = i_en ? meta : o_q[g];
      end
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          meta <= RESET_VAL[g];
          o_q[g] <= RESET_VAL[g];
        end else begin
          meta <= next_meta;
          o_q[g] <= next_q;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
